/* File: common/lpclk_consts.svh */
// Timing constants and reset levels for the low-power clock handshake
`ifndef LPCLK_CONSTS_SVH
`define LPCLK_CONSTS_SVH

`define LPCLK_CLK_PERIOD_NS    20
`define LPCLK_REQ_RESET        1'h1
`define LPCLK_ACK_RESET        1'h1
`define LPCLK_CREQ_RESET       1'h1
`define LPCLK_CREQ_TO_ACK_CYC  1
`define LPCLK_DOWN_SEQ_CYC     4
`define LPCLK_UP_SEQ_CYC       4
`define LPCLK_SEQ_CNT_W        8

`endif

/* File: common/lpclk_pkg.sv */
// Types shared by both ends of the low-power clock handshake
package lpclk_pkg;

  typedef enum logic [2:0] {
    LPCLK_RUN,
    LPCLK_POWER_DOWN,
    LPCLK_ACK_DELAY,
    LPCLK_LOW_POWER,
    LPCLK_POWER_UP,
    LPCLK_WAIT_REQ,
    LPCLK_DENIED
  } lpclk_dev_state_t;

  typedef enum logic [2:0] {
    LPCLK_C_RUN,
    LPCLK_C_WAIT_ENTRY,
    LPCLK_C_GATED,
    LPCLK_C_WAIT_EXIT
  } lpclk_ctl_state_t;

endpackage : lpclk_pkg

/* File: common/lpclk_if.sv */
// Interface joining peripheral end and clock controller end
`timescale 1ns/100ps
interface lpclk_if;
  logic clock_required;
  logic lowpower_request;
  logic lowpower_ack;

  modport periph (
    output clock_required,
    output lowpower_ack,
    input  lowpower_request
  );

  modport ctrl (
    input  clock_required,
    input  lowpower_ack,
    output lowpower_request
  );
endinterface : lpclk_if

/* File: core/lpclk_periph.sv */
// Peripheral end of the low-power clock handshake
`timescale 1ns/100ps
`include "lpclk_consts.svh"

// ****************************************************************
// Overview of operation
// ****************************************************************
module lpclk_periph
  import lpclk_pkg::*;
#(
  parameter int DOWN_CYC = `LPCLK_DOWN_SEQ_CYC, // Power-down sequence length
  parameter int UP_CYC   = `LPCLK_UP_SEQ_CYC    // Power-up sequence length
) (
  input  wire logic clock_i,       // Peripheral clock
  input  wire logic arst_n_i,      // Async reset, active low
  lpclk_if.periph   lp,            // Handshake link
  input  wire logic busy_i,        // Work pending, clock needed
  input  wire logic allow_entry_i, // Accept entry requests when high
  output logic      low_power_o,   // In low-power state
  output logic      seq_active_o   // Power-down or power-up running
);

  lpclk_dev_state_t                   state_ff;
  lpclk_dev_state_t                   nxt_state;
  logic [`LPCLK_SEQ_CNT_W-1:0]        cnt_ff;
  logic [`LPCLK_SEQ_CNT_W-1:0]        nxt_cnt;
  logic                               creq_ff;
  logic                               ack_ff;
  logic                               nxt_creq;
  logic                               nxt_ack;
  logic                               lp_ff;
  logic                               seq_ff;

  // ****************************************************************
  // Handshake and status outputs
  // ****************************************************************
  // Driven from a register, never tied: this end has a sequence
  assign lp.clock_required = creq_ff;
  assign lp.lowpower_ack   = ack_ff;
  assign low_power_o       = lp_ff;
  assign seq_active_o      = seq_ff;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Counter sits on the last cycle of a phase of len cycles
  function automatic logic cnt_last(input logic [`LPCLK_SEQ_CNT_W-1:0] cnt,
                                    input int                           len);
    return cnt == `LPCLK_SEQ_CNT_W'(len - 1);
  endfunction : cnt_last

  // States in which a power sequence is counting
  function automatic logic in_seq(input lpclk_dev_state_t st);
    return (st == LPCLK_POWER_DOWN) || (st == LPCLK_POWER_UP);
  endfunction : in_seq

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_creq  = creq_ff;
    nxt_ack   = ack_ff;
    unique case (state_ff)
      LPCLK_RUN: begin
        // Refusal answers at once with required held high
        nxt_creq = 1'h1;
        if (!lp.lowpower_request) begin
          if (allow_entry_i && !busy_i) begin
            nxt_state = LPCLK_POWER_DOWN;
            nxt_cnt   = '0;
          end else begin
            nxt_ack   = 1'h0;
            nxt_state = LPCLK_DENIED;
          end
        end
      end
      LPCLK_POWER_DOWN: begin
        if (busy_i) begin
          // Late work: refuse instead of stranding it
          nxt_ack   = 1'h0;
          nxt_state = LPCLK_DENIED;
        end else if (cnt_last(cnt_ff, DOWN_CYC)) begin
          nxt_creq  = 1'h0;
          nxt_cnt   = '0;
          nxt_state = LPCLK_ACK_DELAY;
        end else begin
          nxt_cnt = cnt_ff + `LPCLK_SEQ_CNT_W'(1);
        end
      end
      LPCLK_ACK_DELAY: begin
        // Keeps a full cycle between required drop and ack drop
        if (cnt_last(cnt_ff, `LPCLK_CREQ_TO_ACK_CYC)) begin
          nxt_ack   = 1'h0;
          nxt_state = LPCLK_LOW_POWER;
        end else begin
          nxt_cnt = cnt_ff + `LPCLK_SEQ_CNT_W'(1);
        end
      end
      LPCLK_LOW_POWER: begin
        // Either side may start the exit; request wins a tie
        if (lp.lowpower_request) begin
          nxt_cnt   = '0;
          nxt_state = LPCLK_POWER_UP;
        end else if (busy_i) begin
          nxt_creq  = 1'h1;
          nxt_state = LPCLK_WAIT_REQ;
        end
      end
      LPCLK_POWER_UP: begin
        // Required rises only once the wake sequence is done
        if (cnt_last(cnt_ff, UP_CYC)) begin
          nxt_creq  = 1'h1;
          nxt_state = LPCLK_WAIT_REQ;
        end else begin
          nxt_cnt = cnt_ff + `LPCLK_SEQ_CNT_W'(1);
        end
      end
      LPCLK_WAIT_REQ: begin
        // Ack rises one cycle after required in controller exit
        if (lp.lowpower_request) begin
          nxt_ack   = 1'h1;
          nxt_state = LPCLK_RUN;
        end
      end
      LPCLK_DENIED: begin
        // Clock never stopped here; only the exit half remains
        if (lp.lowpower_request) begin
          nxt_ack   = 1'h1;
          nxt_state = LPCLK_RUN;
        end
      end
      default: nxt_state = LPCLK_RUN;
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= LPCLK_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Phase counter
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // Handshake registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      creq_ff <= `LPCLK_CREQ_RESET;
      ack_ff  <= `LPCLK_ACK_RESET;
    end else begin
      creq_ff <= nxt_creq;
      ack_ff  <= nxt_ack;
    end
  end

  // ****************************************************************
  // Status registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_ff  <= 1'h0;
      seq_ff <= 1'h0;
    end else begin
      lp_ff  <= (nxt_state == LPCLK_LOW_POWER);
      seq_ff <= in_seq(nxt_state);
    end
  end

endmodule : lpclk_periph

/* File: core/lpclk_ctrl.sv */
// Clock controller end of the low-power clock handshake
`timescale 1ns/100ps
`include "lpclk_consts.svh"

module lpclk_ctrl
  import lpclk_pkg::*;
(
  input  wire logic clock_i,      // Free-running controller clock
  input  wire logic arst_n_i,     // Async reset, active low
  lpclk_if.ctrl     lp,           // Handshake link
  input  wire logic sleep_i,      // Ask peripheral to enter low power
  output logic      clk_enable_o, // Enable for the peripheral clock gate
  output logic      refused_o     // Last entry request was refused
);

  lpclk_ctl_state_t state_ff;
  logic             req_ff;
  logic             en_ff;
  logic             ref_ff;
  logic             creq_s1_ff;
  logic             creq_s2_ff;
  logic             ack_s1_ff;
  logic             ack_s2_ff;

  // One request line; a shared domain fans it out to every member
  assign lp.lowpower_request = req_ff;
  assign clk_enable_o        = en_ff;
  assign refused_o           = ref_ff;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      creq_s1_ff <= `LPCLK_CREQ_RESET;
      creq_s2_ff <= `LPCLK_CREQ_RESET;
      ack_s1_ff  <= `LPCLK_ACK_RESET;
      ack_s2_ff  <= `LPCLK_ACK_RESET;
    end else begin
      // Domain of one member: the OR and the last edge are its own
      creq_s1_ff <= lp.clock_required;
      creq_s2_ff <= creq_s1_ff;
      ack_s1_ff  <= lp.lowpower_ack;
      ack_s2_ff  <= ack_s1_ff;
    end
  end

  // ****************************************************************
  // Handshake sequencer
  // ****************************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= LPCLK_C_RUN;
      req_ff   <= `LPCLK_REQ_RESET;
      ref_ff   <= 1'h0;
    end else begin
      unique case (state_ff)
        LPCLK_C_RUN: begin
          if (sleep_i && ack_s2_ff) begin
            req_ff   <= 1'h0;
            state_ff <= LPCLK_C_WAIT_ENTRY;
          end
        end
        LPCLK_C_WAIT_ENTRY: begin
          if (!ack_s2_ff) begin
            ref_ff   <= creq_s2_ff;
            state_ff <= creq_s2_ff ? LPCLK_C_WAIT_EXIT : LPCLK_C_GATED;
            if (creq_s2_ff) begin
              req_ff <= 1'h1;
            end
          end
        end
        LPCLK_C_GATED: begin
          if (!sleep_i || creq_s2_ff) begin
            req_ff   <= 1'h1;
            state_ff <= LPCLK_C_WAIT_EXIT;
          end
        end
        LPCLK_C_WAIT_EXIT: begin
          if (ack_s2_ff) begin
            state_ff <= LPCLK_C_RUN;
          end
        end
        default: state_ff <= LPCLK_C_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Clock gate control
  // ****************************************************************
  // Raw required keeps enable fast; gating only in gated state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_ff <= 1'h1;
    end else begin
      en_ff <= lp.clock_required || creq_s2_ff
               || (state_ff != LPCLK_C_GATED) || !sleep_i;
    end
  end

endmodule : lpclk_ctrl

/* File: verif/lpclk_asserts.sv */
// Concurrent checks on the wires between peripheral and controller ends
`timescale 1ns/100ps
module lpclk_asserts (
  input wire logic clock_i,          // Shared clock
  input wire logic arst_n_i,         // Async reset, active low
  input wire logic clock_required,   // Peripheral needs its clock
  input wire logic lowpower_request, // Entry low, exit high
  input wire logic lowpower_ack      // Follows request when recognized
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // ****************************************
  // Handshake order
  // ****************************************
  chk_ack_fall_req: assert property ($fell(lowpower_ack) |-> !lowpower_request)
    else $error("acknowledge fell without entry request");
  chk_req_fall_ack: assert property ($fell(lowpower_request) |-> lowpower_ack)
    else $error("entry requested before exit finished");
  chk_req_rise_ack: assert property ($rose(lowpower_request) |-> !lowpower_ack)
    else $error("exit requested before entry answered");
  chk_entry_answer: assert property ($fell(lowpower_request) |-> ##[1:24] !lowpower_ack)
    else $error("entry request not answered");
  chk_exit_answer: assert property ($rose(lowpower_request) |-> ##[1:24] lowpower_ack)
    else $error("exit request not answered");
  // ****************************************
  // Clock required against request and acknowledge
  // ****************************************
  chk_accept_gap: assert property ($fell(lowpower_ack) && !clock_required
    |-> !$past(clock_required))
    else $error("acknowledge fell with required drop");
  chk_ack_rise_cr: assert property ($rose(lowpower_ack)
    |-> lowpower_request && $past(clock_required))
    else $error("acknowledge rose before clock required");
  chk_cr_fall_req: assert property ($fell(clock_required) |-> !lowpower_request)
    else $error("clock required dropped without request");
  chk_wake_req: assert property (!lowpower_ack && $rose(clock_required)
    |-> ##[1:24] lowpower_request)
    else $error("peripheral wake not followed by exit request");
  cov_accept: cover property ($fell(lowpower_ack) && !clock_required);
  cov_refuse: cover property ($fell(lowpower_ack) && clock_required);
  cov_wake: cover property ($rose(clock_required) && !lowpower_request);
endmodule : lpclk_asserts

/* File: verif/testbench.sv */
// Self-checking bench joining both ends of the low-power clock handshake
`timescale 1ns/100ps
module testbench;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        busy_i = 1'b0;
  logic        allow_entry_i = 1'b1;
  logic        sleep_i = 1'b0;
  logic        low_power_o, seq_active_o, clk_enable_o, refused_o, acc;
  logic [31:0] r;
  integer      seed = 32'h0591;
  int          n_fail = 0;
  int          n_checks = 0;

  always #10 clock_i = ~clock_i;

  lpclk_if lpclk_if_inst ();
  lpclk_periph lpclk_periph_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .lp(lpclk_if_inst),
    .busy_i(busy_i), .allow_entry_i(allow_entry_i), .low_power_o(low_power_o),
    .seq_active_o(seq_active_o));
  lpclk_ctrl lpclk_ctrl_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .lp(lpclk_if_inst),
    .sleep_i(sleep_i), .clk_enable_o(clk_enable_o), .refused_o(refused_o));
  lpclk_asserts lpclk_asserts_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .clock_required(lpclk_if_inst.clock_required),
    .lowpower_request(lpclk_if_inst.lowpower_request),
    .lowpower_ack(lpclk_if_inst.lowpower_ack));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic exp_accept(input logic busy, input logic allow);
    return !busy && allow;
  endfunction : exp_accept

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t level %b, expected %b", $time, seen, exp);
    end
  endtask : check

  // Inputs change 1 ns after the edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic wait_ack(input logic v);
    for (int i = 0; i < 40 && lpclk_if_inst.lowpower_ack !== v; i++) tick(1);
    if (lpclk_if_inst.lowpower_ack !== v) begin
      n_fail++;
      $display("FAIL %0t acknowledge wait ran out", $time);
      test_done();
    end
  endtask : wait_ack

  task automatic settle();
    sleep_i = 1'b0;
    busy_i = 1'b0;
    allow_entry_i = 1'b1;
    tick(8);
    wait_ack(1'b1);
    tick(4);
    check(lpclk_if_inst.lowpower_request, 1'b1);
    check(lpclk_if_inst.lowpower_ack, 1'b1);
  endtask : settle

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(4);
    check(lpclk_if_inst.lowpower_request, 1'b1);
    check(lpclk_if_inst.lowpower_ack, 1'b1);
    check(clk_enable_o, 1'b1);
    arst_n_i = 1'b1;
    tick(2);
    // First pass plain accept, second a late busy mid power-down
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      busy_i = (k < 2) ? 1'b0 : r[0];
      allow_entry_i = (k < 2) ? 1'b1 : (r[1] | r[2]);
      sleep_i = 1'b1;
      if (k == 1) begin
        tick(4);
        check(seq_active_o, 1'b1);
        busy_i = 1'b1;
      end
      acc = exp_accept(busy_i, allow_entry_i);
      wait_ack(1'b0);
      check(lpclk_if_inst.clock_required, !acc);
      check(low_power_o, acc);
      check(seq_active_o, 1'b0);
      if (acc) begin
        tick(4);
        check(clk_enable_o, 1'b0);
        check(lpclk_if_inst.lowpower_ack, 1'b0);
        if (r[3]) begin
          sleep_i = 1'b0;
        end else begin
          busy_i = 1'b1;
        end
        wait_ack(1'b1);
        check(lpclk_if_inst.clock_required, 1'b1);
      end else begin
        wait_ack(1'b1);
        check(lpclk_if_inst.lowpower_request, 1'b1);
      end
      check(clk_enable_o, 1'b1);
      check(refused_o, !acc);
      settle();
    end
    test_done();
  end
endmodule : testbench
